/* core/tptc_pkg.sv */
// Purpose: Constants, types and register layout of the transmit pulse
//          template configuration block.
// Assumes: One clock, one asynchronous active-low reset.
// Notes:   Shared by the register bank, its checker and its bench.
//
// Operation
// - Monitor runs while disable bit 5 clear
// - Bit 4 set floats line driver only
// - Four-bit select picks E1, DSX1, J1 template
// - Codes 1000-1011 reserved; 11XX selects user waveform
// - Six-bit scale, reset 100001, scales user pulses
// - T1/J1 nominal 110110, two percent per step
// - E1 nominal 100001, three percent per step
// - Writing bit 7 one starts indirect access
// - Direction bit 6: zero writes, one reads
// - Bits 5-4 pick unit interval, 00 leftmost
// - Bits 3-0 pick one of sixteen samples
// - Data field feeds writes, receives read results

package tptc_pkg;

	// ****************************************************************
	// Register offsets on the host register port
	// ****************************************************************
	localparam logic [7:0] OFF_DRV_TEMPLATE = 8'h06;
	localparam logic [7:0] OFF_AMP_SCALE    = 8'h07;
	localparam logic [7:0] OFF_RAM_CTRL     = 8'h08;
	localparam logic [7:0] OFF_RAM_DATA     = 8'h09;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int BIT_MON_DISABLE  = 5;
	localparam int BIT_DRV_FLOAT    = 4;
	localparam int BIT_RAM_START    = 7;
	localparam int BIT_RAM_DIR      = 6;
	localparam int POS_INTERVAL_LSB = 4;
	localparam int POS_SAMPLE_LSB   = 0;

	// ****************************************************************
	// Values after reset
	// ****************************************************************
	localparam logic       RST_MON_DISABLE = 1'b0;
	localparam logic       RST_DRV_FLOAT   = 1'b1;
	localparam logic [3:0] RST_TEMPLATE    = 4'h0;
	localparam logic [5:0] RST_AMP_SCALE   = 6'h21;
	localparam logic [6:0] RST_SAMPLE_AMP  = 7'h00;

	// ****************************************************************
	// Template codes and amplitude scaling figures
	// ****************************************************************
	localparam logic [3:0] TPL_E1_75       = 4'h0;
	localparam logic [3:0] TPL_E1_120      = 4'h1;
	localparam logic [3:0] TPL_J1_110      = 4'h7;
	localparam logic [1:0] TPL_USER_PREFIX = 2'h3;
	localparam logic [1:0] TPL_RSVD_PREFIX = 2'h2;
	localparam logic [5:0] NOM_SCALE_T1    = 6'h36;
	localparam logic [5:0] NOM_SCALE_E1    = 6'h21;
	localparam logic [1:0] STEP_PCT_T1     = 2'h2;
	localparam logic [1:0] STEP_PCT_E1     = 2'h3;
	localparam logic signed [10:0] GAIN_BASE_PCT = 11'sh064;

	// ****************************************************************
	// Template memory shape
	// ****************************************************************
	localparam int RAM_DATA_W = 7;
	localparam int RAM_ADDR_W = 6;

	// Indirect access sequencer
	typedef enum logic [1:0] {
		ACC_IDLE = 2'b00,
		ACC_XFER = 2'b01,
		ACC_CAPT = 2'b10
	} tptc_acc_state_e;

	// One host register port request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tptc_host_req_s;

	// Settings handed to the transmit driver and waveform shaper
	typedef struct packed {
		logic       monitor_en;
		logic       driver_float;
		logic [3:0] template_select;
		logic       user_waveform;
		logic       template_reserved;
		logic [1:0] scale_step_pct;
		logic [7:0] gain_pct;
		logic       access_busy;
	} tptc_tx_cfg_s;

endpackage : tptc_pkg

/* core/tptc_template_ram.sv */
// Purpose: Pulse template memory with one write port and two read ports.
// Assumes: Read data valid one clock after the read request.
// Notes:   Contents are not reset; only the read registers are.

`timescale 1ns/100ps
`default_nettype none

module tptc_template_ram #(
	parameter int DATA_W = 7,
	parameter int ADDR_W = 6,
	parameter int DEPTH  = 64
) (
	// Clock and reset
	input  wire logic              clk_in,
	input  wire logic              resetn_in,
	// Host side indirect port
	input  wire logic              host_we_in,
	input  wire logic              host_re_in,
	input  wire logic [ADDR_W-1:0] host_addr_in,
	input  wire logic [DATA_W-1:0] host_wdata_in,
	output logic      [DATA_W-1:0] host_rdata_out,
	// Shaper playback port
	input  wire logic [ADDR_W-1:0] play_addr_in,
	output logic      [DATA_W-1:0] play_rdata_out
);

	logic [DATA_W-1:0] mem_r [DEPTH];

	// Storage keeps its samples until rewritten
	always_ff @(posedge clk_in) begin
		if (host_we_in) begin
			mem_r[host_addr_in] <= host_wdata_in;
		end
	end

	// Registered host read
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			host_rdata_out <= '0;
		end else if (host_re_in) begin
			host_rdata_out <= mem_r[host_addr_in];
		end
	end

	// Playback read runs every cycle; write-through not needed for shaping
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			play_rdata_out <= '0;
		end else begin
			play_rdata_out <= mem_r[play_addr_in];
		end
	end

endmodule : tptc_template_ram

`default_nettype wire

/* core/tptc_regs.sv */
// Purpose: Transmit driver, template select, amplitude scale and indirect
//          template memory access registers.
// Assumes: Host port strobes are one-cycle, synchronous to clk_in.
// Notes:   Read data appear one clock after the read strobe.

`timescale 1ns/100ps
`default_nettype none

module tptc_regs #(
	parameter int DATA_W = tptc_pkg::RAM_DATA_W,
	parameter int ADDR_W = tptc_pkg::RAM_ADDR_W
) (
	// Clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  resetn_in,
	// Host register port
	input  wire tptc_pkg::tptc_host_req_s host_req_in,
	output logic [7:0]                 host_rdata_out,
	// Line mode for user waveform scaling
	input  wire logic                  t1_mode_in,
	// Waveform shaper playback
	input  wire logic [ADDR_W-1:0]     shaper_addr_in,
	output logic [DATA_W-1:0]          user_sample_out,
	// Transmit settings
	output tptc_pkg::tptc_tx_cfg_s     tx_cfg_out
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic                          mon_disable_r;
	logic                          drv_float_r;
	logic [3:0]                    template_r;
	logic [5:0]                    scale_r;
	logic                          dir_read_r;
	logic [1:0]                    interval_addr_r;
	logic [3:0]                    sample_addr_r;
	logic [DATA_W-1:0]             sample_amp_r;
	tptc_pkg::tptc_acc_state_e     state_r;
	tptc_pkg::tptc_acc_state_e     state_nxt;
	logic                          wr_drv;
	logic                          wr_scale;
	logic                          wr_ctrl;
	logic                          wr_data;
	logic                          idle;
	logic                          start;
	logic                          ram_we;
	logic                          ram_re;
	logic [ADDR_W-1:0]             ram_addr;
	logic [DATA_W-1:0]             ram_rdata;
	logic [7:0]                    rdata_nxt;
	logic                          is_e1_tpl;
	logic                          is_t1_tpl;
	logic                          use_t1_scale;
	logic [5:0]                    nominal;
	logic [1:0]                    step_pct;
	logic signed [10:0]            scale_diff;
	logic signed [10:0]            gain_full;
	logic [7:0]                    gain_nxt;
	tptc_pkg::tptc_tx_cfg_s        cfg_nxt;

	// ****************************************************************
	// Address decode
	// ****************************************************************

	// Write strobes per register; unmapped addresses match none, so
	// their writes fall away without touching any state
	assign wr_drv   = host_req_in.wr && (host_req_in.addr == tptc_pkg::OFF_DRV_TEMPLATE);
	assign wr_scale = host_req_in.wr && (host_req_in.addr == tptc_pkg::OFF_AMP_SCALE);
	assign wr_ctrl  = host_req_in.wr && (host_req_in.addr == tptc_pkg::OFF_RAM_CTRL);
	assign wr_data  = host_req_in.wr && (host_req_in.addr == tptc_pkg::OFF_RAM_DATA);

	// Control writes only land while no access is in flight; a start
	// with bit 7 clear only updates direction and address
	assign idle  = (state_r == tptc_pkg::ACC_IDLE);
	assign start = wr_ctrl && idle && host_req_in.wdata[tptc_pkg::BIT_RAM_START];

	// ****************************************************************
	// Driver and template select register
	// ****************************************************************

	// Reserved bits 7-6 are dropped on write and read back as zero.
	// Float only tristates the line driver; encoder and shaper keep
	// running, so the line comes back without a restart
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			mon_disable_r <= tptc_pkg::RST_MON_DISABLE;
			drv_float_r   <= tptc_pkg::RST_DRV_FLOAT;
			template_r    <= tptc_pkg::RST_TEMPLATE;
		end else if (wr_drv) begin
			mon_disable_r <= host_req_in.wdata[tptc_pkg::BIT_MON_DISABLE];
			drv_float_r   <= host_req_in.wdata[tptc_pkg::BIT_DRV_FLOAT];
			template_r    <= host_req_in.wdata[3:0];
		end
	end

	// ****************************************************************
	// Amplitude scale register
	// ****************************************************************

	// Six-bit scale factor; the gain of every template, fixed or user,
	// is derived from it against the nominal of its family
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			scale_r <= tptc_pkg::RST_AMP_SCALE;
		end else if (wr_scale) begin
			scale_r <= host_req_in.wdata[5:0];
		end
	end

	// ****************************************************************
	// Indirect access control and data
	// ****************************************************************

	// One access per start: a write spends one transfer cycle, a read
	// a transfer and a capture cycle. Software polls the start bit,
	// which reads as busy, before touching the data register again.
	// A control write while busy is dropped whole, so a stray retry
	// cannot retarget the access in flight. Limitation: a host write
	// to the data register during a read capture is lost.

	// Direction and address; frozen while busy so the access stays coherent
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			dir_read_r      <= 1'b0;
			interval_addr_r <= 2'h0;
			sample_addr_r   <= 4'h0;
		end else if (wr_ctrl && idle) begin
			dir_read_r      <= host_req_in.wdata[tptc_pkg::BIT_RAM_DIR];
			interval_addr_r <= host_req_in.wdata[tptc_pkg::POS_INTERVAL_LSB +: 2];
			sample_addr_r   <= host_req_in.wdata[tptc_pkg::POS_SAMPLE_LSB +: 4];
		end
	end

	// Sample amplitude; a read result wins over a host write in the same cycle
	// Holds its value across accesses so a write can reuse the last read
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sample_amp_r <= tptc_pkg::RST_SAMPLE_AMP;
		end else if (state_r == tptc_pkg::ACC_CAPT) begin
			sample_amp_r <= ram_rdata;
		end else if (wr_data) begin
			sample_amp_r <= host_req_in.wdata[DATA_W-1:0];
		end
	end

	// Sequencer state; reset lands in idle, so no access can start
	// from reset alone
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_r <= tptc_pkg::ACC_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Write finishes in the transfer cycle; read needs a capture cycle
	// because the memory read data come out of a register
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			tptc_pkg::ACC_IDLE: begin
				if (start) begin
					state_nxt = tptc_pkg::ACC_XFER;
				end
			end
			tptc_pkg::ACC_XFER: begin
				state_nxt = dir_read_r ? tptc_pkg::ACC_CAPT : tptc_pkg::ACC_IDLE;
			end
			tptc_pkg::ACC_CAPT: begin
				state_nxt = tptc_pkg::ACC_IDLE;
			end
			default: begin
				state_nxt = tptc_pkg::ACC_IDLE;
			end
		endcase
	end

	// Memory strobes; entry index is interval above sample.
	// The address is frozen while busy, so it never moves under a strobe
	assign ram_we   = (state_r == tptc_pkg::ACC_XFER) && !dir_read_r;
	assign ram_re   = (state_r == tptc_pkg::ACC_XFER) && dir_read_r;
	assign ram_addr = {interval_addr_r, sample_addr_r};

	// ****************************************************************
	// Template memory
	// ****************************************************************

	// Sixty-four seven-bit samples. Playback reads every cycle and is
	// never blocked by host accesses; a sample rewritten while it plays
	// appears on the next read, so templates are best rewritten while
	// a fixed template is selected
	tptc_template_ram #(
		.DATA_W (DATA_W),
		.ADDR_W (ADDR_W),
		.DEPTH  (1 << ADDR_W)
	) u_template_ram (
		.clk_in         (clk_in),
		.resetn_in      (resetn_in),
		.host_we_in     (ram_we),
		.host_re_in     (ram_re),
		.host_addr_in   (ram_addr),
		.host_wdata_in  (sample_amp_r),
		.host_rdata_out (ram_rdata),
		.play_addr_in   (shaper_addr_in),
		.play_rdata_out (user_sample_out)
	);

	// ****************************************************************
	// Host read path
	// ****************************************************************

	// Start bit reads as one until the access completes, so the same
	// bit serves as the busy flag. Data register bit 7 and every
	// unmapped address read as zero; nothing here has read side
	// effects, so a speculative read is harmless
	always_comb begin
		rdata_nxt = 8'h00;
		case (host_req_in.addr)
			tptc_pkg::OFF_DRV_TEMPLATE: begin
				rdata_nxt = {2'b00, mon_disable_r, drv_float_r, template_r};
			end
			tptc_pkg::OFF_AMP_SCALE: begin
				rdata_nxt = {2'b00, scale_r};
			end
			tptc_pkg::OFF_RAM_CTRL: begin
				rdata_nxt = {!idle, dir_read_r, interval_addr_r, sample_addr_r};
			end
			tptc_pkg::OFF_RAM_DATA: begin
				rdata_nxt = {1'b0, sample_amp_r};
			end
			default: begin
				rdata_nxt = 8'h00;
			end
		endcase
	end

	// Read data held until the next read strobe; writes never
	// disturb what software last read
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			host_rdata_out <= 8'h00;
		end else if (host_req_in.rd) begin
			host_rdata_out <= rdata_nxt;
		end
	end

	// ****************************************************************
	// Template classification and amplitude gain
	// ****************************************************************

	// E1 templates versus DSX1 and J1 templates; the five DSX1 cable
	// ranges and J1 share one nominal scale and one step
	assign is_e1_tpl = (template_r == tptc_pkg::TPL_E1_75)
	                || (template_r == tptc_pkg::TPL_E1_120);
	assign is_t1_tpl = !is_e1_tpl && (template_r <= tptc_pkg::TPL_J1_110);

	// User and reserved codes carry no family of their own, so they
	// fall back to the global line mode for nominal and step
	assign use_t1_scale = is_t1_tpl || (!is_e1_tpl && t1_mode_in);
	assign nominal      = use_t1_scale ? tptc_pkg::NOM_SCALE_T1 : tptc_pkg::NOM_SCALE_E1;
	assign step_pct     = use_t1_scale ? tptc_pkg::STEP_PCT_T1 : tptc_pkg::STEP_PCT_E1;

	// Percent gain relative to nominal: 100 plus the step times the
	// signed distance from nominal. Small scales on the two percent
	// family would go negative, so the result clamps at zero; the
	// largest scale on the three percent family stays below 256
	always_comb begin
		scale_diff = $signed({5'b0_0000, scale_r}) - $signed({5'b0_0000, nominal});
		gain_full  = tptc_pkg::GAIN_BASE_PCT + scale_diff * $signed({9'h000, step_pct});
		gain_nxt   = (gain_full < 0) ? 8'h00 : gain_full[7:0];
	end

	// Settings bundle for the driver and shaper; reserved codes
	// pass through flagged, with no override
	always_comb begin
		cfg_nxt                   = '0;
		cfg_nxt.monitor_en        = !mon_disable_r;
		cfg_nxt.driver_float      = drv_float_r;
		cfg_nxt.template_select   = template_r;
		cfg_nxt.user_waveform     = (template_r[3:2] == tptc_pkg::TPL_USER_PREFIX);
		cfg_nxt.template_reserved = (template_r[3:2] == tptc_pkg::TPL_RSVD_PREFIX);
		cfg_nxt.scale_step_pct    = step_pct;
		cfg_nxt.gain_pct          = gain_nxt;
		cfg_nxt.access_busy       = !idle;
	end

	// Registered so the analog side sees glitch-free settings. This
	// costs one cycle after each register write; the reset image
	// matches the register reset values field by field, so nothing
	// glitches on the first edge after reset
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			tx_cfg_out                 <= '0;
			tx_cfg_out.monitor_en      <= !tptc_pkg::RST_MON_DISABLE;
			tx_cfg_out.driver_float    <= tptc_pkg::RST_DRV_FLOAT;
			tx_cfg_out.template_select <= tptc_pkg::RST_TEMPLATE;
			tx_cfg_out.scale_step_pct  <= tptc_pkg::STEP_PCT_E1;
			tx_cfg_out.gain_pct        <= tptc_pkg::GAIN_BASE_PCT[7:0];
		end else begin
			tx_cfg_out <= cfg_nxt;
		end
	end

endmodule : tptc_regs

`default_nettype wire

/* verification/tptc_regs_properties.sv */
// Purpose: Port-level checker for the transmit template register bank.
// Assumes: One clock domain, reset active low, host strobes one cycle long.
// Notes:   Write-to-settings checks allow two edges for the registered copy.

`timescale 1ns/100ps
`default_nettype none

module tptc_regs_properties #(
	parameter int DATA_W = 7,
	parameter int ADDR_W = 6
) (
	// Clock and reset
	input  wire logic                     clk_in,
	input  wire logic                     resetn_in,
	// Host side
	input  wire tptc_pkg::tptc_host_req_s host_req_in,
	input  wire logic [7:0]               host_rdata_out,
	input  wire logic                     t1_mode_in,
	// Shaper and settings
	input  wire logic [ADDR_W-1:0]        shaper_addr_in,
	input  wire logic [DATA_W-1:0]        user_sample_out,
	input  wire tptc_pkg::tptc_tx_cfg_s   tx_cfg_out
);
	// ************************************************************
	// Helpers
	// ************************************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	// Decoded host events
	wire w06   = host_req_in.wr && host_req_in.addr == tptc_pkg::OFF_DRV_TEMPLATE;
	wire start = host_req_in.wr && host_req_in.addr == tptc_pkg::OFF_RAM_CTRL
		&& host_req_in.wdata[7];
	wire unmap = host_req_in.rd && (host_req_in.addr < 8'h06 || host_req_in.addr > 8'h09);

	// ************************************************************
	// Assertions
	// ************************************************************
	a_monitor_follows_bit: assert property (
		w06 |-> ##2 tx_cfg_out.monitor_en == !$past(host_req_in.wdata[5], 2))
		else $error("monitor enable does not follow bit 5");
	a_float_follows_bit: assert property (
		w06 |-> ##2 tx_cfg_out.driver_float == $past(host_req_in.wdata[4], 2))
		else $error("driver float does not follow bit 4");
	a_select_copy_taken: assert property (
		w06 |-> ##2 tx_cfg_out.template_select == $past(host_req_in.wdata[3:0], 2))
		else $error("template select not taken");
	a_user_code_flag: assert property (
		tx_cfg_out.user_waveform == (tx_cfg_out.template_select[3:2] == 2'b11))
		else $error("user waveform flag wrong");
	a_reserved_code_flag: assert property (
		tx_cfg_out.template_reserved == (tx_cfg_out.template_select[3:2] == 2'b10))
		else $error("reserved template flag wrong");
	a_step_by_family: assert property (
		!tx_cfg_out.template_select[3] |-> tx_cfg_out.scale_step_pct ==
		((tx_cfg_out.template_select[3:1] == 3'b000) ? 2'h3 : 2'h2))
		else $error("scaling step wrong for template family");
	a_unmapped_reads_zero: assert property (
		unmap |-> ##2 host_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_holds_idle: assert property (
		(!host_req_in.rd && !$past(host_req_in.rd)) |=> $stable(host_rdata_out))
		else $error("read data changed without a read");
	a_start_sets_busy: assert property (
		(start && !tx_cfg_out.access_busy) |-> ##[1:3] tx_cfg_out.access_busy)
		else $error("indirect access never went busy");
	a_busy_ends_soon: assert property (
		$rose(tx_cfg_out.access_busy) |-> ##[1:4] !tx_cfg_out.access_busy)
		else $error("indirect access stuck busy");
endmodule : tptc_regs_properties

`default_nettype wire

/* verification/tptc_regs_tb.sv */
// Purpose: Self-checking bench for the transmit template register bank.
// Assumes: 10 MHz clock, inputs changed by non-blocking assignment at edges.
// Notes:   Memory is not reset, so retention is checked across a reset.

`timescale 1ns/100ps
`default_nettype none

module tptc_regs_tb;
	// ************************************************************
	// Signals and design
	// ************************************************************
	localparam logic [7:0] A06 = tptc_pkg::OFF_DRV_TEMPLATE;
	localparam logic [7:0] A07 = tptc_pkg::OFF_AMP_SCALE;
	localparam logic [7:0] A08 = tptc_pkg::OFF_RAM_CTRL;
	localparam logic [7:0] A09 = tptc_pkg::OFF_RAM_DATA;
	logic                     clk_in = 1'b0;
	logic                     resetn_in = 1'b0;
	tptc_pkg::tptc_host_req_s req = '0;
	logic                     t1_mode = 1'b0;
	logic [5:0]               shaper_addr = 6'h00;
	logic [7:0]               rdata;
	logic [6:0]               sample;
	tptc_pkg::tptc_tx_cfg_s   tx;
	int                       num_errors = 0;
	int                       checks = 0;

	tptc_regs u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .host_req_in(req),
		.host_rdata_out(rdata), .t1_mode_in(t1_mode), .shaper_addr_in(shaper_addr),
		.user_sample_out(sample), .tx_cfg_out(tx));

	// Free-running clock, 100 ns period
	always #50 clk_in = ~clk_in;

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in) req <= {1'b1, 1'b0, a, d};
		@(posedge clk_in) req <= '0;
	endtask : wr

	// Answer lands one edge after the strobe edge, then holds
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in) req <= {1'b0, 1'b1, a, 8'h00};
		@(posedge clk_in) req <= '0;
		@(posedge clk_in) #1 d = rdata;
	endtask : rd

	task rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd(a, v);
		chk(v, exp, "register read");
	endtask : rdchk

	// Bounded poll of the busy bit
	task wait_idle();
		logic [7:0] v;
		v = 8'h80;
		for (int n = 0; n < 20 && v[7] !== 1'b0; n++) rd(A08, v);
		chk({7'h00, v[7]}, 8'h00, "access busy");
	endtask : wait_idle

	function automatic bit fam_t1(input logic [3:0] c, input logic t1);
		return c[3] ? t1 : (c > 4'h1);
	endfunction : fam_t1

	function automatic logic [7:0] gain_of(input logic [3:0] c, input logic [5:0] s,
		input logic t1);
		int g;
		int si;
		si = s;
		g = fam_t1(c, t1) ? 100 + (si - 54) * 2 : 100 + (si - 33) * 3;
		if (g < 0) g = 0;
		return g[7:0];
	endfunction : gain_of

	// Settings copy after the registered delay
	task cfgchk(input logic [3:0] c, input logic [5:0] s);
		repeat (2) @(posedge clk_in);
		#1;
		chk({4'h0, tx.template_select}, {4'h0, c}, "select");
		chk({7'h00, tx.user_waveform}, {7'h00, c[3:2] == 2'b11}, "user");
		chk({7'h00, tx.template_reserved}, {7'h00, c[3:2] == 2'b10}, "reserved");
		chk({6'h00, tx.scale_step_pct}, fam_t1(c, t1_mode) ? 8'h02 : 8'h03, "step");
		chk(tx.gain_pct, gain_of(c, s, t1_mode), "gain");
	endtask : cfgchk

	// ************************************************************
	// Scenarios
	// ************************************************************
	task t_reset_values();
		rdchk(A06, 8'h10);
		rdchk(A07, 8'h21);
		rdchk(A08, 8'h00);
		rdchk(A09, 8'h00);
		chk({6'h00, tx.monitor_en, tx.driver_float}, 8'h03, "reset drive");
		cfgchk(4'h0, 6'h21);
		wr(8'h0A, 8'hFF);
		rdchk(8'h0A, 8'h00);
		rdchk(8'h05, 8'h00);
	endtask : t_reset_values

	task t_driver_bits();
		wr(A06, 8'h20);
		cfgchk(4'h0, 6'h21);
		chk({6'h00, tx.monitor_en, tx.driver_float}, 8'h00, "drive 20");
		wr(A06, 8'h30);
		rdchk(A06, 8'h30);
		chk({6'h00, tx.monitor_en, tx.driver_float}, 8'h01, "drive 30");
	endtask : t_driver_bits

	task t_templates();
		for (int m = 0; m < 2; m++) begin
			@(posedge clk_in) t1_mode <= m[0];
			// Reserved codes are never selected by software
			for (int c = 0; c < 16; c++) begin
				if (c[3:2] != 2'b10) begin
					wr(A06, {4'h0, c[3:0]});
					cfgchk(c[3:0], 6'h21);
				end
			end
		end
	endtask : t_templates

	// Scale boundaries against each template family
	task t_scale();
		logic [5:0] sv [4] = '{6'h00, 6'h20, 6'h22, 6'h3F};
		logic [3:0] cv [4] = '{4'h0, 4'h2, 4'h7, 4'hC};
		foreach (sv[i]) foreach (cv[j]) begin
			wr(A07, {2'b11, sv[i]});
			wr(A06, {4'h0, cv[j]});
			cfgchk(cv[j], sv[i]);
			rdchk(A07, {2'b00, sv[i]});
		end
	endtask : t_scale

	task t_ram();
		for (int i = 0; i < 64; i++) begin
			wr(A09, {1'b1, 7'(i * 7 + 9)});
			wr(A08, {2'b10, i[5:0]});
			wait_idle();
		end
		for (int i = 0; i < 64; i++) begin
			wr(A08, {2'b11, i[5:0]});
			@(posedge clk_in) #1 chk({7'h00, tx.access_busy}, 8'h01, "busy flag");
			wait_idle();
			rdchk(A09, {1'b0, 7'(i * 7 + 9)});
			rdchk(A08, {2'b01, i[5:0]});
			@(posedge clk_in) shaper_addr <= i[5:0];
			repeat (2) @(posedge clk_in);
			#1 chk({1'b0, sample}, {1'b0, 7'(i * 7 + 9)}, "playback");
		end
	endtask : t_ram

	task t_mid_reset();
		wr(A06, 8'h25);
		@(posedge clk_in) resetn_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		resetn_in <= 1'b1;
		rdchk(A06, 8'h10);
		rdchk(A07, 8'h21);
		wr(A08, 8'hCA);
		wait_idle();
		rdchk(A09, {1'b0, 7'(10 * 7 + 9)});
	endtask : t_mid_reset

	// ************************************************************
	// Sequence, watchdog and verdict
	// ************************************************************
	task end_of_test();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test

	// Main sequence after a four-cycle reset
	initial begin
		repeat (4) @(posedge clk_in);
		resetn_in <= 1'b1;
		t_reset_values();
		t_driver_bits();
		t_templates();
		t_scale();
		t_ram();
		t_mid_reset();
		end_of_test();
	end

	// Hang guard at 20000 cycles, well past the expected run of under two thousand cycles
	initial begin
		#(20000 * 100);
		num_errors++;
		end_of_test();
	end
endmodule : tptc_regs_tb

bind tptc_regs tptc_regs_properties #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_props (
	.clk_in(clk_in), .resetn_in(resetn_in), .host_req_in(host_req_in),
	.host_rdata_out(host_rdata_out), .t1_mode_in(t1_mode_in),
	.shaper_addr_in(shaper_addr_in), .user_sample_out(user_sample_out),
	.tx_cfg_out(tx_cfg_out));

`default_nettype wire
